//--- design/rsm_regulator_status.sv
`timescale 1ns/100ps
// Summary of operation
// - converter enable on bits 7 and 3
// - converter raw invalid output on bits 6, 2
// - converter current limit on bits 4, 0
// - linear regulator enable on bits 7, 3
// - linear regulator raw invalid on bits 6, 2
// - linear regulator limit on bits 4, 0
// - mask one bit 7 blocks power-good, default 1
// - masks gate interrupts only, status stays live
// - mask one bit 4 blocks clock detect, default 1
// - mask one bit 2 blocks thermal, default 0
// - mask one bit 0 blocks load meas, default 0
// - mask two bit 0 blocks register reset
// - power-good flags latch until written one
module rsm_regulator_status
    import rsm_pkg::*;
(
    input  wire logic       sys_clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       clk_en_i,
    input  wire logic       wr_en_i,
    input  wire logic       rd_en_i,
    input  wire logic [7:0] addr_i,
    input  wire logic [7:0] wdata_i,
    output logic      [7:0] rdata_o,
    output logic            rvalid_o,
    input  wire logic       load_otp_i,
    input  wire logic [7:0] otp_mask_one_i,
    input  wire logic [7:0] otp_mask_two_i,
    input  wire logic [1:0] conv_enabled_i,
    input  wire logic [1:0] conv_output_invalid_i,
    input  wire logic [1:0] conv_current_limiting_i,
    input  wire logic [1:0] linreg_enabled_i,
    input  wire logic [1:0] linreg_output_invalid_i,
    input  wire logic [1:0] linreg_current_limiting_i,
    output logic            power_good_irq_en_o,
    output logic            ext_clock_irq_en_o,
    output logic            thermal_warn_irq_en_o,
    output logic            load_meas_irq_en_o,
    output logic            reg_reset_irq_en_o,
    output logic            power_good_event_o
);
    import rsm_pkg::*;

    logic [7:0] top_interrupt_mask_one;
    logic [7:0] top_interrupt_mask_two;
    logic [7:0] converter_status;
    logic [7:0] linear_regulator_status;
    logic [1:0] conv_pg_flag;
    logic [1:0] linreg_pg_flag;
    logic [1:0] conv_pg_clear;
    logic [1:0] linreg_pg_clear;
    logic [7:0] next_rdata;

    // one layout serves both status registers
    function automatic logic [7:0] pack_status(input logic [1:0] en,
                                                input logic [1:0] inv,
                                                input logic [1:0] lim);
        logic [7:0] s;
        s = 8'h00;
        s[POS_UNIT1_ENABLED]  = en[1];
        s[POS_UNIT1_INVALID]  = inv[1];
        s[POS_UNIT1_LIMITING] = lim[1];
        s[POS_UNIT0_ENABLED]  = en[0];
        s[POS_UNIT0_INVALID]  = inv[0];
        s[POS_UNIT0_LIMITING] = lim[0];
        return s;
    endfunction : pack_status

    // status is built straight from the live inputs, never stored
    assign converter_status = pack_status(conv_enabled_i,
        conv_output_invalid_i, conv_current_limiting_i);
    assign linear_regulator_status = pack_status(linreg_enabled_i,
        linreg_output_invalid_i, linreg_current_limiting_i);

    // mask one: reserved bits stay zero; load_otp_i is the device reset
    // sequence, so the memory image overrides any earlier host write
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            top_interrupt_mask_one <= MASK_ONE_RESET;
        end else if (clk_en_i) begin
            if (load_otp_i) begin
                top_interrupt_mask_one <= otp_mask_one_i
                                          & MASK_ONE_WRITABLE;
            end else if (wr_en_i && addr_i == ADDR_TOP_MASK_ONE) begin
                top_interrupt_mask_one <= wdata_i & MASK_ONE_WRITABLE;
            end
        end
    end

    // mask two: host writes never land, only the memory image does
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            top_interrupt_mask_two <= MASK_TWO_RESET;
        end else if (clk_en_i && load_otp_i) begin
            top_interrupt_mask_two <= otp_mask_two_i
                                      & MASK_TWO_WRITABLE;
        end
    end

    // gates for the interrupt logic; status registers are not touched
    assign power_good_irq_en_o   =
        !top_interrupt_mask_one[POS_POWER_GOOD_BLOCK];
    assign ext_clock_irq_en_o    =
        !top_interrupt_mask_one[POS_EXT_CLOCK_BLOCK];
    assign thermal_warn_irq_en_o =
        !top_interrupt_mask_one[POS_THERMAL_BLOCK];
    assign load_meas_irq_en_o    =
        !top_interrupt_mask_one[POS_LOAD_MEAS_BLOCK];
    assign reg_reset_irq_en_o    =
        !top_interrupt_mask_two[POS_REG_RESET_BLOCK];

    // power-good flags, cleared by writing one to the flag positions
    always_comb begin
        conv_pg_clear   = 2'h0;
        linreg_pg_clear = 2'h0;
        if (wr_en_i && addr_i == ADDR_INT_CONVERTER) begin
            conv_pg_clear = {wdata_i[POS_UNIT1_INVALID],
                             wdata_i[POS_UNIT0_INVALID]};
        end
        if (wr_en_i && addr_i == ADDR_INT_LINEAR_REG) begin
            linreg_pg_clear = {wdata_i[POS_UNIT1_INVALID],
                               wdata_i[POS_UNIT0_INVALID]};
        end
    end

    rsm_pg_flags u_conv_flags (
        .sys_clk_i (sys_clk_i),
        .rst_n_i   (rst_n_i),
        .clk_en_i  (clk_en_i),
        .invalid_i (conv_output_invalid_i),
        .clear_i   (conv_pg_clear),
        .flag_o    (conv_pg_flag)
    );

    rsm_pg_flags u_linreg_flags (
        .sys_clk_i (sys_clk_i),
        .rst_n_i   (rst_n_i),
        .clk_en_i  (clk_en_i),
        .invalid_i (linreg_output_invalid_i),
        .clear_i   (linreg_pg_clear),
        .flag_o    (linreg_pg_flag)
    );

    // flags always latch; only the outgoing request is masked
    assign power_good_event_o = power_good_irq_en_o
                                && (|conv_pg_flag || |linreg_pg_flag);

    // read mux; unmapped addresses read zero, status writes fall away
    always_comb begin
        next_rdata = 8'h00;
        unique case (addr_i)
            ADDR_CONVERTER_STATUS:  next_rdata = converter_status;
            ADDR_LINEAR_REG_STATUS: next_rdata = linear_regulator_status;
            ADDR_TOP_MASK_ONE:      next_rdata = top_interrupt_mask_one;
            ADDR_TOP_MASK_TWO:      next_rdata = top_interrupt_mask_two;
            ADDR_INT_CONVERTER:     next_rdata = {1'b0, conv_pg_flag[1],
                                        3'h0, conv_pg_flag[0], 2'h0};
            ADDR_INT_LINEAR_REG:    next_rdata = {1'b0, linreg_pg_flag[1],
                                        3'h0, linreg_pg_flag[0], 2'h0};
            default:                next_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_o  <= 8'h00;
            rvalid_o <= 1'b0;
        end else if (clk_en_i) begin
            rvalid_o <= rd_en_i;
            if (rd_en_i) begin
                rdata_o <= next_rdata;
            end
        end
    end

    sequence s_mask_one_write;
        clk_en_i && !load_otp_i && wr_en_i && addr_i == ADDR_TOP_MASK_ONE;
    endsequence : s_mask_one_write

    a_status_live: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        clk_en_i && rd_en_i && addr_i == ADDR_CONVERTER_STATUS
        |=> rdata_o == $past(converter_status))
        else $error("converter status read not live");
    a_read_valid: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        clk_en_i && rd_en_i |=> rvalid_o)
        else $error("read answered without valid");
    a_conv_bits: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        converter_status[7] == conv_enabled_i[1]
        && converter_status[2] == conv_output_invalid_i[0]
        && converter_status[4] == conv_current_limiting_i[1])
        else $error("converter status bit misplaced");
    a_linreg_bits: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        linear_regulator_status[3] == linreg_enabled_i[0]
        && linear_regulator_status[6] == linreg_output_invalid_i[1]
        && linear_regulator_status[0] == linreg_current_limiting_i[0])
        else $error("linear regulator status bit misplaced");
    a_reserved_zero: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (top_interrupt_mask_one & 8'h6A) == 8'h00
        && top_interrupt_mask_two[7:1] == 7'h00)
        else $error("reserved mask bit set");
    a_mask2_locked: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        clk_en_i && !load_otp_i && wr_en_i && addr_i == ADDR_TOP_MASK_TWO
        |=> $stable(top_interrupt_mask_two))
        else $error("host write changed register reset mask");
    a_mask1_write: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        s_mask_one_write |=> power_good_irq_en_o == !$past(wdata_i[7])
            && thermal_warn_irq_en_o == !$past(wdata_i[2]))
        else $error("mask one write not applied");
    a_otp_reload: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        clk_en_i && load_otp_i |=> top_interrupt_mask_one
            == ($past(otp_mask_one_i) & MASK_ONE_WRITABLE))
        else $error("mask one not reloaded from memory");
    a_pg_gated: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        top_interrupt_mask_one[POS_POWER_GOOD_BLOCK] |-> !power_good_event_o
        && converter_status[6] == conv_output_invalid_i[1])
        else $error("masked power-good still raised");
endmodule : rsm_regulator_status

//--- include/rsm_pkg.sv
package rsm_pkg;
    // register addresses on the serial register port
    localparam logic [7:0] ADDR_CONVERTER_STATUS  = 8'h1E;
    localparam logic [7:0] ADDR_LINEAR_REG_STATUS = 8'h1F;
    localparam logic [7:0] ADDR_TOP_MASK_ONE      = 8'h20;
    localparam logic [7:0] ADDR_TOP_MASK_TWO      = 8'h21;
    localparam logic [7:0] ADDR_INT_CONVERTER     = 8'h1B;
    localparam logic [7:0] ADDR_INT_LINEAR_REG    = 8'h1C;

    // status field positions (same layout in both status registers)
    localparam int POS_UNIT1_ENABLED  = 7;
    localparam int POS_UNIT1_INVALID  = 6;
    localparam int POS_UNIT1_LIMITING = 4;
    localparam int POS_UNIT0_ENABLED  = 3;
    localparam int POS_UNIT0_INVALID  = 2;
    localparam int POS_UNIT0_LIMITING = 0;

    // mask field positions
    localparam int POS_POWER_GOOD_BLOCK = 7;
    localparam int POS_EXT_CLOCK_BLOCK  = 4;
    localparam int POS_THERMAL_BLOCK    = 2;
    localparam int POS_LOAD_MEAS_BLOCK  = 0;
    localparam int POS_REG_RESET_BLOCK  = 0;

    // writable bits of each mask register; other bits are reserved
    localparam logic [7:0] MASK_ONE_WRITABLE = 8'h95;
    localparam logic [7:0] MASK_TWO_WRITABLE = 8'h01;

    // power-good flag positions in the latched interrupt registers
    localparam logic [7:0] PG_FLAG_BITS = 8'h44;

    // fallback reset values, used before the memory image is taken
    localparam logic [7:0] MASK_ONE_RESET = 8'h90;
    localparam logic [7:0] MASK_TWO_RESET = 8'h01;
endpackage : rsm_pkg

//--- design/rsm_pg_flags.sv
`timescale 1ns/100ps
// latched power-good flags for one pair of regulators, write 1 to clear
module rsm_pg_flags (
    input  wire logic       sys_clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       clk_en_i,
    input  wire logic [1:0] invalid_i,
    input  wire logic [1:0] clear_i,
    output logic      [1:0] flag_o
);
    logic [1:0] invalid_q;
    logic [1:0] event_pg;

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            invalid_q <= 2'h0;
        end else if (clk_en_i) begin
            invalid_q <= invalid_i;
        end
    end

    // either edge of the raw validity is a power-good event
    assign event_pg = invalid_q ^ invalid_i;

    // set wins over a clear in the same cycle
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            flag_o <= 2'h0;
        end else if (clk_en_i) begin
            flag_o <= (flag_o & ~clear_i) | event_pg;
        end
    end

    a_flag_holds: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        clk_en_i && flag_o[0] && !clear_i[0] |=> flag_o[0])
        else $error("power-good flag dropped without a clear");
    a_set_wins: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        clk_en_i && event_pg[1] |=> flag_o[1])
        else $error("power-good event lost to a clear");
endmodule : rsm_pg_flags

//--- bench/rsm_host_model.sv
`timescale 1ns/100ps
module rsm_host_model (
    input  wire logic       sys_clk_i,
    input  wire logic [7:0] rdata_i,
    input  wire logic       rvalid_i,
    output logic            wr_en_o,
    output logic            rd_en_o,
    output logic      [7:0] addr_o,
    output logic      [7:0] wdata_o
);
    initial begin
        wr_en_o = 1'b0;
        rd_en_o = 1'b0;
        addr_o  = 8'h00;
        wdata_o = 8'h00;
    end

    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        #1;
        addr_o  = a;
        wdata_o = d;
        wr_en_o = 1'b1;
        @(posedge sys_clk_i);
        #1;
        wr_en_o = 1'b0;
        // released data flips so a stale byte is never mistaken for a write
        wdata_o = ~d;
    endtask : write_reg

    task automatic read_reg(input logic [7:0] a, output logic [7:0] d,
                            output logic ok);
        @(posedge sys_clk_i);
        #1;
        addr_o  = a;
        rd_en_o = 1'b1;
        @(posedge sys_clk_i);
        #1;
        rd_en_o = 1'b0;
        ok      = rvalid_i;
        d       = rdata_i;
    endtask : read_reg
endmodule : rsm_host_model

//--- bench/tb_top.sv
`timescale 1ns/100ps
module tb_top;
    import rsm_pkg::*;
    logic       sys_clk_i = 1'b0;
    logic       rst_n_i   = 1'b0;
    logic       wr_en, rd_en, rvalid, load_otp = 1'b0;
    logic       clk_en = 1'b1;
    logic [7:0] addr, wdata, rdata;
    logic [7:0] otp_one = 8'h94, otp_two = 8'h00;
    logic [1:0] ce = 2'h0, ci = 2'h0, cl = 2'h0;
    logic [1:0] le = 2'h0, li = 2'h0, ll = 2'h0;
    logic       pg_en, ck_en, th_en, lm_en, rr_en, pg_ev;
    int         fails = 0;
    int         checks = 0;

    always #2.5 sys_clk_i = ~sys_clk_i;

    rsm_regulator_status dut (
        .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .clk_en_i(clk_en),
        .wr_en_i(wr_en), .rd_en_i(rd_en), .addr_i(addr), .wdata_i(wdata),
        .rdata_o(rdata), .rvalid_o(rvalid), .load_otp_i(load_otp),
        .otp_mask_one_i(otp_one), .otp_mask_two_i(otp_two),
        .conv_enabled_i(ce), .conv_output_invalid_i(ci),
        .conv_current_limiting_i(cl), .linreg_enabled_i(le),
        .linreg_output_invalid_i(li), .linreg_current_limiting_i(ll),
        .power_good_irq_en_o(pg_en), .ext_clock_irq_en_o(ck_en),
        .thermal_warn_irq_en_o(th_en), .load_meas_irq_en_o(lm_en),
        .reg_reset_irq_en_o(rr_en), .power_good_event_o(pg_ev));

    rsm_host_model host (
        .sys_clk_i(sys_clk_i), .rdata_i(rdata), .rvalid_i(rvalid),
        .wr_en_o(wr_en), .rd_en_o(rd_en), .addr_o(addr), .wdata_o(wdata));

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic       ok;
        host.read_reg(a, d, ok);
        chk({7'h00, ok}, 8'h01);
        chk(d, exp);
    endtask : rd

    function automatic logic [7:0] stat(input logic [1:0] e, i, l);
        return {e[1], i[1], 1'b0, l[1], e[0], i[0], 1'b0, l[0]};
    endfunction : stat

    task automatic stop_test();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : stop_test

    initial begin
        #100000;
        fails++;
        stop_test();
    end

    initial begin
        repeat (12) @(posedge sys_clk_i);
        #1;
        rst_n_i = 1'b1;
        rd(ADDR_TOP_MASK_ONE, 8'h90);
        rd(ADDR_TOP_MASK_TWO, 8'h01);
        chk({3'h0, pg_en, ck_en, th_en, lm_en, rr_en}, 8'h06);
        for (int k = 0; k < 4; k++) begin
            {ce, ci, cl} = {2'(k), ~2'(k), 2'(k) ^ 2'h1};
            {le, li, ll} = {~2'(k), 2'(k), 2'(k) ^ 2'h2};
            rd(ADDR_CONVERTER_STATUS, stat(ce, ci, cl));
            rd(ADDR_LINEAR_REG_STATUS, stat(le, li, ll));
        end
        host.write_reg(ADDR_CONVERTER_STATUS, 8'h00);
        host.write_reg(ADDR_LINEAR_REG_STATUS, 8'hFF);
        rd(ADDR_CONVERTER_STATUS, stat(ce, ci, cl));
        rd(ADDR_LINEAR_REG_STATUS, stat(le, li, ll));
        host.write_reg(ADDR_TOP_MASK_ONE, 8'hFF);
        rd(ADDR_TOP_MASK_ONE, 8'h95);
        chk({4'h0, pg_en, ck_en, th_en, lm_en}, 8'h00);
        li = ~li;
        rd(ADDR_LINEAR_REG_STATUS, stat(le, li, ll));
        host.write_reg(ADDR_TOP_MASK_ONE, 8'h00);
        rd(ADDR_TOP_MASK_ONE, 8'h00);
        chk({4'h0, pg_en, ck_en, th_en, lm_en}, 8'h0F);
        ci = ~ci;
        rd(ADDR_CONVERTER_STATUS, stat(ce, ci, cl));
        host.write_reg(ADDR_TOP_MASK_TWO, 8'hFE);
        rd(ADDR_TOP_MASK_TWO, 8'h01);
        chk({7'h00, rr_en}, 8'h00);
        // earlier status sweeps may have latched flags; start clean
        host.write_reg(ADDR_INT_CONVERTER, PG_FLAG_BITS);
        host.write_reg(ADDR_INT_LINEAR_REG, PG_FLAG_BITS);
        rd(ADDR_INT_CONVERTER, 8'h00);
        chk({7'h00, pg_ev}, 8'h00);
        ci[1] = ~ci[1];
        repeat (2) @(posedge sys_clk_i);
        rd(ADDR_INT_CONVERTER, 8'h40);
        host.write_reg(ADDR_INT_CONVERTER, 8'h00);
        rd(ADDR_INT_CONVERTER, 8'h40);
        chk({7'h00, pg_ev}, 8'h01);
        host.write_reg(ADDR_INT_CONVERTER, 8'h40);
        rd(ADDR_INT_CONVERTER, 8'h00);
        chk({7'h00, pg_ev}, 8'h00);
        // set wins when an event meets a clear in one cycle
        fork
            host.write_reg(ADDR_INT_CONVERTER, 8'h40);
            begin
                @(posedge sys_clk_i);
                #1;
                ci[1] = ~ci[1];
            end
        join
        rd(ADDR_INT_CONVERTER, 8'h40);
        host.write_reg(ADDR_INT_CONVERTER, PG_FLAG_BITS);
        li[0] = ~li[0];
        host.write_reg(ADDR_TOP_MASK_ONE, 8'h80);
        rd(ADDR_INT_LINEAR_REG, 8'h04);
        chk({7'h00, pg_ev}, 8'h00);
        host.write_reg(ADDR_INT_LINEAR_REG, 8'h04);
        rd(ADDR_INT_LINEAR_REG, 8'h00);
        @(posedge sys_clk_i);
        #1;
        load_otp = 1'b1;
        @(posedge sys_clk_i);
        #1;
        load_otp = 1'b0;
        rd(ADDR_TOP_MASK_ONE, 8'h94);
        rd(ADDR_TOP_MASK_TWO, 8'h00);
        chk({7'h00, rr_en}, 8'h01);
        // a write while the clock enable is low must not land
        clk_en = 1'b0;
        host.write_reg(ADDR_TOP_MASK_ONE, 8'h00);
        clk_en = 1'b1;
        rd(ADDR_TOP_MASK_ONE, 8'h94);
        rst_n_i = 1'b0;
        repeat (2) @(posedge sys_clk_i);
        #1;
        rst_n_i = 1'b1;
        rd(ADDR_TOP_MASK_ONE, 8'h90);
        rd(ADDR_TOP_MASK_TWO, 8'h01);
        rd(8'h30, 8'h00);
        stop_test();
    end
endmodule : tb_top
